/* File: rtl/csr_block_pkg.sv */
// Constants shared by the controller status word, index pointer and helper modules
package csr_block_pkg;

    // Host port selection: index pointer or data port
    localparam logic       PORT_INDEX        = 1'b0;
    localparam logic       PORT_DATA         = 1'b1;

    // Index pointer layout
    localparam int         INDEX_WIDTH       = 7;
    localparam logic [6:0] INDEX_RESET       = 7'h00;

    // Register indices reached through the data port
    localparam logic [6:0] IDX_STATUS_WORD   = 7'h00;
    localparam logic [6:0] IDX_MASK_WORD     = 7'h03;

    // Status word bit positions
    localparam int         BIT_FAULT_SUM     = 15;
    localparam int         BIT_FLAG_HI       = 14;
    localparam int         BIT_FLAG_LO       = 8;
    localparam int         BIT_INT_PEND      = 7;
    localparam int         BIT_IRQ_GATE      = 6;
    localparam int         BIT_RX_ACTIVE     = 5;
    localparam int         BIT_TX_ACTIVE     = 4;
    localparam int         BIT_POLL_REQ      = 3;
    localparam int         BIT_STOP          = 2;
    localparam int         BIT_START         = 1;
    localparam int         BIT_INIT          = 0;

    // Sticky flag vector, index = status bit minus BIT_FLAG_LO
    localparam int         FLAG_COUNT        = 7;
    localparam int         FL_BABBLE         = 6;
    localparam int         FL_COLL_FAULT     = 5;
    localparam int         FL_DROPPED        = 4;
    localparam int         FL_GRANT_FAULT    = 3;
    localparam int         FL_RX_DONE        = 2;
    localparam int         FL_TX_DONE        = 1;
    localparam int         FL_INIT_DONE      = 0;
    // Flags able to raise an interrupt; the collision test fault never does
    localparam logic [6:0] FLAG_IRQ_CAPABLE  = 7'h5F;
    localparam logic [6:0] FLAG_RESET        = 7'h00;
    localparam logic [6:0] MASK_RESET        = 7'h00;

    // Timing
    localparam int         CLK_PERIOD_NS     = 25;
    localparam int         BIT_TIME_NS       = 100;
    localparam int         COLL_WINDOW_BITS  = 20;
    localparam int         GRANT_TIMEOUT_US  = 50;
    // Longest wait, rounded down
    localparam int         COLL_WINDOW_CYC   = (COLL_WINDOW_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
    // Least wait, rounded up
    localparam int         GRANT_TIMEOUT_CYC = (GRANT_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Babble threshold: the 1519th byte of a frame trips it
    localparam logic [10:0] BABBLE_BYTES     = 11'h5EF;
    localparam logic [10:0] BYTE_COUNT_RESET = 11'h000;

endpackage : csr_block_pkg

/* File: rtl/interval_timer.sv */
// Cycle timer that fires once after running for a set number of cycles
`timescale 1ns/10ps
module interval_timer #(
    parameter logic [15:0] LIMIT = 16'h0001
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Timer control and result
    input  wire logic run,
    output logic      expired_q
);

    logic [15:0] count_q;
    logic        fired_q;

    // Counting restarts whenever run drops, so only an unbroken wait fires
    always_ff @(posedge core_clk) begin
        if (reset || !run) begin
            count_q   <= 16'h0000;
            fired_q   <= 1'b0;
            expired_q <= 1'b0;
        end else if (!fired_q && count_q == LIMIT - 16'h0001) begin
            fired_q   <= 1'b1;
            expired_q <= 1'b1;
        end else begin
            count_q   <= fired_q ? count_q : count_q + 16'h0001;
            expired_q <= 1'b0;
        end
    end

    property p_timer_needs_run;
        @(posedge core_clk) disable iff (reset) !run |=> !expired_q;
    endproperty
    a_timer_needs_run: assert property (p_timer_needs_run) else $error("timer fired without run");

endmodule : interval_timer

/* File: rtl/sticky_flags.sv */
// Bank of sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/10ps
module sticky_flags #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Set, clear and wipe controls
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clear_vec,
    input  wire logic             wipe,
    // Flag state
    output logic      [WIDTH-1:0] flags_q
);

    // One flag per bit; a set in the clearing cycle wins so no event is lost
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            always_ff @(posedge core_clk) begin
                if (reset || wipe) begin
                    flags_q[i] <= 1'b0;
                end else if (set_vec[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (clear_vec[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    property p_set_wins;
        @(posedge core_clk) disable iff (reset) (set_vec[0] && clear_vec[0] && !wipe) |=> flags_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost on simultaneous set and clear");

    property p_clear_one;
        @(posedge core_clk) disable iff (reset) (clear_vec[0] && !set_vec[0]) |=> !flags_q[0];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("write one did not clear flag");

endmodule : sticky_flags

/* File: rtl/controller_status_and_index_port.sv */
// Index pointer and controller status word with its command and flag logic
// Function
// - Index pointer keeps a 7-bit select field; upper bits read zero.
// - Reset clears the index pointer field.
// - Bit 15 is the read-only OR of four error flags.
// - Babble flag sets when a transmitted frame reaches 1519 bytes.
// - Interrupt line asserts for unmasked causes only while irq_gate is one.
// - Sticky flags set by hardware, cleared by writing one, reset or stop.
// - Collision test fault on missing collision after send outside twisted-pair mode, or link-fail send in that mode.
// - Collision test fault never interrupts but feeds the summary bit.
// - Dropped frame flag sets when no receive descriptor is free.
// - Bus grant fault sets when acknowledge is missing 50 us after request.
// - Receive done flag sets after frame received and last buffer returned.
// - Transmit done flag sets after frame sent and last buffer returned.
// - Init done flag sets once the initialization block is read.
// - Interrupt pending is read-only OR of all unmasked causes while not stopped; stop holds it low.
// - irq_gate follows written value; reset or stop clears it.
// - Poll request forces ring check; dropped when transmitter inactive.
// - Poll request set by writing one, cleared by fetch, reset or stop.
// - Stop halts activity until start or init; stop wins over both.
`timescale 1ns/10ps
module controller_status_and_index_port
    import csr_block_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Host register port
    input  wire logic        host_write,
    input  wire logic        host_read,
    input  wire logic        port_select,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata_q,
    // Configuration levels
    input  wire logic        receive_disable,
    input  wire logic        transmit_disable,
    // Transmit engine events
    input  wire logic        tx_frame_start,
    input  wire logic        tx_byte_sent,
    input  wire logic        tx_frame_end,
    input  wire logic        tp_mode,
    input  wire logic        link_fail,
    // Descriptor manager and initialization events
    input  wire logic        rx_frame_dropped,
    input  wire logic        rx_done_event,
    input  wire logic        tx_done_event,
    input  wire logic        init_done_event,
    input  wire logic        descriptor_fetch,
    // Other interrupt causes, already masked elsewhere
    input  wire logic        missed_count_overflow,
    input  wire logic        collision_count_overflow,
    input  wire logic        line_overdrive_flag,
    input  wire logic        transmit_start_flag,
    // Bus mastership
    input  wire logic        bus_master,
    input  wire logic        drq_active,
    input  wire logic        dack_pin,
    input  wire logic        collision_pin,
    // Controller state to the rest of the chip
    output logic             stop_q,
    output logic             start_command_q,
    output logic             init_command_q,
    output logic             receiver_active_q,
    output logic             transmitter_active_q,
    output logic             transmit_poll_request_q,
    output logic             irq_q
);

    logic [INDEX_WIDTH-1:0] index_q;
    logic [6:0]             mask_q;
    logic                   irq_gate_q;
    logic                   wait_init_q;
    logic                   coll_wait_q;
    logic [10:0]            byte_count_q;
    logic [1:0]             pin_meta_q;
    logic [1:0]             pin_sync_q;
    logic [6:0]             flags_q;
    logic                   coll_expired;
    logic                   grant_expired;

    // Pins from outside pass two flip-flops before any logic sees them
    always_ff @(posedge core_clk) begin
        pin_meta_q <= {collision_pin, dack_pin};
        pin_sync_q <= pin_meta_q;
    end

    wire coll_sync = pin_sync_q[1];
    wire dack_sync = pin_sync_q[0];

    // Access decode
    wire wr_index  = host_write && port_select == PORT_INDEX;
    wire wr_data   = host_write && port_select == PORT_DATA;
    wire wr_status = wr_data && index_q == IDX_STATUS_WORD;
    wire wr_mask   = wr_data && index_q == IDX_MASK_WORD;

    // Stop overrides start and init written in the same access
    wire stop_set  = wr_status && host_wdata[BIT_STOP];
    wire start_set = wr_status && host_wdata[BIT_START] && !host_wdata[BIT_STOP];
    wire init_set  = wr_status && host_wdata[BIT_INIT] && !host_wdata[BIT_STOP];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            index_q <= INDEX_RESET;
        end else if (wr_index) begin
            index_q <= host_wdata[INDEX_WIDTH-1:0];
        end
    end

    // Mask register; the collision fault position is reserved and kept zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= host_wdata[BIT_FLAG_HI:BIT_FLAG_LO] & FLAG_IRQ_CAPABLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stop_q          <= 1'b1;
            start_command_q <= 1'b0;
            init_command_q  <= 1'b0;
        end else if (stop_set) begin
            stop_q          <= 1'b1;
            start_command_q <= 1'b0;
            init_command_q  <= 1'b0;
        end else if (start_set || init_set) begin
            stop_q          <= 1'b0;
            start_command_q <= start_command_q || start_set;
            init_command_q  <= init_command_q || init_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || stop_set) begin
            irq_gate_q <= 1'b0;
        end else if (wr_status) begin
            irq_gate_q <= host_wdata[BIT_IRQ_GATE];
        end
    end

    // Joint start and init defers the enables until init completes
    wire enable_now = (start_set && !init_set) || (wait_init_q && init_done_event);

    always_ff @(posedge core_clk) begin
        if (reset || stop_set || enable_now) begin
            wait_init_q <= 1'b0;
        end else if (start_set && init_set) begin
            wait_init_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || stop_set) begin
            receiver_active_q    <= 1'b0;
            transmitter_active_q <= 1'b0;
        end else if (enable_now) begin
            receiver_active_q    <= !receive_disable;
            transmitter_active_q <= !transmit_disable;
        end
    end

    // poll request; a write while idle is dropped, set beats fetch
    wire poll_set = wr_status && host_wdata[BIT_POLL_REQ] && transmitter_active_q;

    always_ff @(posedge core_clk) begin
        if (reset || stop_set || !transmitter_active_q) begin
            transmit_poll_request_q <= 1'b0;
        end else if (poll_set) begin
            transmit_poll_request_q <= 1'b1;
        end else if (descriptor_fetch) begin
            transmit_poll_request_q <= 1'b0;
        end
    end

    // babble byte count, saturating at the threshold
    always_ff @(posedge core_clk) begin
        if (reset || tx_frame_start) begin
            byte_count_q <= BYTE_COUNT_RESET;
        end else if (tx_byte_sent && byte_count_q != BABBLE_BYTES) begin
            byte_count_q <= byte_count_q + 11'h001;
        end
    end

    wire babble_hit = tx_byte_sent && byte_count_q == BABBLE_BYTES - 11'h001;

    // collision test window opens at frame end, closes on collision
    always_ff @(posedge core_clk) begin
        if (reset || stop_set || coll_sync || coll_expired || tp_mode) begin
            coll_wait_q <= 1'b0;
        end else if (tx_frame_end) begin
            coll_wait_q <= 1'b1;
        end
    end

    interval_timer #(.LIMIT(16'(COLL_WINDOW_CYC))) u_coll_timer (
        .core_clk  (core_clk),
        .reset     (reset),
        .run       (coll_wait_q),
        .expired_q (coll_expired)
    );

    // grant wait restarts whenever acknowledge arrives
    interval_timer #(.LIMIT(16'(GRANT_TIMEOUT_CYC))) u_grant_timer (
        .core_clk  (core_clk),
        .reset     (reset),
        .run       (bus_master && drq_active && !dack_sync),
        .expired_q (grant_expired)
    );

    // flag sources; a stopped controller raises nothing
    wire coll_fault = coll_expired || (tp_mode && link_fail && tx_byte_sent);
    wire [6:0] flag_set = stop_q ? FLAG_RESET :
        {babble_hit, coll_fault, rx_frame_dropped, grant_expired, rx_done_event, tx_done_event, init_done_event};
    wire [6:0] flag_clear = wr_status ? host_wdata[BIT_FLAG_HI:BIT_FLAG_LO] : FLAG_RESET;

    sticky_flags #(.WIDTH(FLAG_COUNT)) u_flags (
        .core_clk  (core_clk),
        .reset     (reset),
        .set_vec   (flag_set),
        .clear_vec (flag_clear),
        .wipe      (stop_set),
        .flags_q   (flags_q)
    );

    wire fault_sum = |flags_q[FL_BABBLE:FL_GRANT_FAULT];
    // pending causes; collision fault excluded by the capable mask
    wire other_causes = missed_count_overflow || collision_count_overflow || line_overdrive_flag || transmit_start_flag;
    wire int_pending  = !stop_q && (|(flags_q & ~mask_q & FLAG_IRQ_CAPABLE) || other_causes);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_gate_q && int_pending;
        end
    end

    // Read views; upper pointer bits and unmapped indices read zero
    wire [15:0] index_view  = {9'h000, index_q};
    wire [15:0] status_view = {fault_sum, flags_q, int_pending, irq_gate_q, receiver_active_q,
                               transmitter_active_q, transmit_poll_request_q, stop_q, start_command_q, init_command_q};
    wire [15:0] mask_view   = {1'b0, mask_q, 8'h00};
    wire [15:0] data_view   = index_q == IDX_STATUS_WORD ? status_view :
                              index_q == IDX_MASK_WORD   ? mask_view   : 16'h0000;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_rdata_q <= 16'h0000;
        end else if (host_read) begin
            host_rdata_q <= port_select == PORT_INDEX ? index_view : data_view;
        end
    end

    property p_index_upper_zero;
        @(posedge core_clk) disable iff (reset) (host_read && port_select == PORT_INDEX) |=> host_rdata_q[15:7] == 9'h000;
    endproperty
    a_index_upper_zero: assert property (p_index_upper_zero) else $error("index upper bits not zero");

    property p_index_reset;
        @(posedge core_clk) reset |=> index_q == INDEX_RESET;
    endproperty
    a_index_reset: assert property (p_index_reset) else $error("index not cleared by reset");

    property p_fault_read;
        @(posedge core_clk) disable iff (reset) (host_read && port_select == PORT_DATA && index_q == IDX_STATUS_WORD)
            |=> host_rdata_q[BIT_FAULT_SUM] == $past(|flags_q[FL_BABBLE:FL_GRANT_FAULT]);
    endproperty
    a_fault_read: assert property (p_fault_read) else $error("summary bit wrong on read");

    property p_irq_follows;
        @(posedge core_clk) disable iff (reset) (irq_gate_q && int_pending) |=> irq_q;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("interrupt line missed a pending cause");

    property p_irq_gated;
        @(posedge core_clk) disable iff (reset) !irq_gate_q |=> !irq_q;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("interrupt active with gate closed");

    property p_coll_silent;
        @(posedge core_clk) disable iff (reset) (flags_q == 7'h20 && !other_causes) |=> !irq_q;
    endproperty
    a_coll_silent: assert property (p_coll_silent) else $error("collision fault raised interrupt");

    property p_coll_sets;
        @(posedge core_clk) disable iff (reset) (coll_expired && !stop_q && !stop_set) |=> flags_q[FL_COLL_FAULT];
    endproperty
    a_coll_sets: assert property (p_coll_sets) else $error("collision window expiry not flagged");

    property p_poll_fetch;
        @(posedge core_clk) disable iff (reset) (descriptor_fetch && !poll_set) |=> !transmit_poll_request_q;
    endproperty
    a_poll_fetch: assert property (p_poll_fetch) else $error("poll request survived fetch");

    property p_stop_wins;
        @(posedge core_clk) disable iff (reset) stop_set |=> (stop_q && !start_command_q && !receiver_active_q);
    endproperty
    a_stop_wins: assert property (p_stop_wins) else $error("stop did not halt controller");

    sequence s_joint_start;
        start_set && init_set;
    endsequence
    sequence s_no_init_yet;
        !init_done_event && !stop_set;
    endsequence
    property p_joint_wait;
        @(posedge core_clk) disable iff (reset) (s_joint_start ##1 s_no_init_yet) |=> !receiver_active_q;
    endproperty
    a_joint_wait: assert property (p_joint_wait) else $error("receiver active before init done");

endmodule : controller_status_and_index_port

/* File: tb/host_port_model.sv */
// Host software model that reaches registers through the index pointer and data port
`timescale 1ns/10ps
module host_port_model (
    // Clock
    input  wire logic        core_clk,
    // Register port
    output logic             host_write,
    output logic             host_read,
    output logic             port_select,
    output logic      [15:0] host_wdata,
    input  wire logic [15:0] host_rdata_q
);
    // Idle port at time zero
    initial begin
        host_write = 1'b0;
        host_read = 1'b0;
        port_select = 1'b0;
        host_wdata = 16'h0000;
    end
    task automatic wr(input logic sel, input logic [15:0] d);
        @(posedge core_clk);
        port_select <= sel;
        host_wdata <= d;
        host_write <= 1'b1;
        @(posedge core_clk);
        host_write <= 1'b0;
        host_wdata <= ~d; // Released bus must not keep the old word
    endtask : wr
    // Read answer is registered one edge after the strobe
    task automatic rd(input logic sel, output logic [15:0] d);
        @(posedge core_clk);
        port_select <= sel;
        host_read <= 1'b1;
        @(posedge core_clk);
        host_read <= 1'b0;
        @(posedge core_clk);
        #1 d = host_rdata_q;
    endtask : rd
endmodule : host_port_model

/* File: tb/tb_top.sv */
// Self-checking bench for the index pointer and controller status word
`timescale 1ns/10ps
module tb_top;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        rxd = 1'b0, txd = 1'b1, bm = 1'b0, drq = 1'b0;
    logic [3:0]  oc = 4'h0;
    wire  [5:0]  ctl;
    logic        tp = 1'b0, lf = 1'b0, dack = 1'b0, cp = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [15:0] rdata, v;
    logic        hw, hr, ps, irq;
    logic [15:0] wd, rq;
    logic [6:0]  m_fl = 7'h00, m_mask = 7'h00;
    logic        m_gate = 1'b0, m_rx = 1'b0, m_tx = 1'b0, m_poll = 1'b0, m_stop = 1'b1, m_start = 1'b0;
    logic        m_init = 1'b0;
    int          seed = 82, bad_count = 0, checked = 0, cyc = 0;

    host_port_model host (.core_clk(core_clk), .host_write(hw), .host_read(hr), .port_select(ps),
        .host_wdata(wd), .host_rdata_q(rq));

    controller_status_and_index_port dut (.core_clk(core_clk), .reset(reset), .host_write(hw),
        .host_read(hr), .port_select(ps), .host_wdata(wd), .host_rdata_q(rq), .receive_disable(rxd),
        .transmit_disable(txd), .tx_frame_start(ev[5]), .tx_byte_sent(ev[6]), .tx_frame_end(ev[7]),
        .tp_mode(tp), .link_fail(lf), .rx_frame_dropped(ev[0]), .rx_done_event(ev[1]),
        .tx_done_event(ev[2]), .init_done_event(ev[3]), .descriptor_fetch(ev[4]),
        .missed_count_overflow(oc[0]), .collision_count_overflow(oc[1]), .line_overdrive_flag(oc[2]),
        .transmit_start_flag(oc[3]), .bus_master(bm), .drq_active(drq), .dack_pin(dack),
        .collision_pin(cp), .stop_q(ctl[5]), .start_command_q(ctl[4]), .init_command_q(ctl[3]),
        .receiver_active_q(ctl[2]), .transmitter_active_q(ctl[1]), .transmit_poll_request_q(ctl[0]),
        .irq_q(irq));

    // Clock at 40 MHz
    always #12.5 core_clk = ~core_clk;

    // Hang guard, well above the longest expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 12000) begin
            bad_count++;
            stop_test();
        end
    end

    // Model of the status word; pending is held low while stopped
    function automatic logic [15:0] exp_st();
        logic pend;
        pend = !m_stop & ((|(m_fl & ~m_mask & 7'h5F)) | (|oc));
        exp_st = {|m_fl[6:3], m_fl, pend, m_gate, m_rx, m_tx, m_poll, m_stop, m_start, m_init};
    endfunction : exp_st

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // Read the status word and compare it and the interrupt line
    task automatic cst();
        host.rd(1'b1, rdata);
        v = exp_st();
        chk(rdata, v);
        chk({15'h0000, irq}, {15'h0000, v[7] & v[6]});
        chk({10'h000, ctl}, {10'h000, m_stop, m_start, m_init, m_rx, m_tx, m_poll});
    endtask : cst

    // Status write through the host, mirrored in the model
    task automatic sw(input logic [15:0] d);
        host.wr(1'b1, d);
        if (d[2]) begin
            {m_fl, m_gate, m_rx, m_tx, m_poll, m_start, m_init} = 13'h0000;
            m_stop = 1'b1;
        end else begin
            m_fl = m_fl & ~d[14:8];
            m_gate = d[6];
            if (d[3] && m_tx) m_poll = 1'b1;
            if (d[1] || d[0]) {m_start, m_init, m_stop} = {m_start | d[1], m_init | d[0], 1'b0};
            // Start with init waits for the init done event
            if (d[1] && !d[0]) {m_rx, m_tx} = {!rxd, !txd};
        end
    endtask : sw

    // Index write with random bits in the dropped upper field
    task automatic six(input logic [6:0] i);
        host.wr(1'b0, (16'($random(seed)) & 16'hFF80) | {9'h000, i});
    endtask : six

    task automatic ev_pulse(input int i);
        @(posedge core_clk);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev <= 8'h00;
    endtask : ev_pulse

    task automatic tend(input string s);
        $display("test %0s done", s);
    endtask : tend

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        host.rd(1'b0, rdata);
        chk(rdata, 16'h0000);
        cst();
        six(7'h03);
        host.rd(1'b0, rdata);
        chk(rdata, 16'h0003);
        six(7'h00);
        tend("reset_index");
        sw(16'h0042);
        cst();
        sw(16'h0048);
        cst();
        sw(16'h0004);
        cst();
        @(posedge core_clk);
        txd <= 1'b0;
        sw(16'h0042);
        cst();
        sw(16'h0048);
        cst();
        ev_pulse(4);
        m_poll = 1'b0;
        cst();
        tend("start_poll");
        // Dropped, receive, transmit and init events in turn
        for (int i = 0; i < 4; i++) begin
            ev_pulse(i);
            m_fl[(i == 0) ? 4 : 3 - i] = 1'b1;
            cst();
        end
        sw(16'h0040);
        cst();
        // set and clear in one cycle
        fork
            ev_pulse(3);
            sw(16'h0140);
        join
        m_fl[0] = 1'b1;
        cst();
        sw(16'h1740);
        cst();
        six(7'h03);
        host.wr(1'b1, 16'h0400);
        m_mask = 7'h04;
        six(7'h00);
        ev_pulse(1);
        m_fl[2] = 1'b1;
        cst();
        sw(16'h0440);
        tend("events_mask");
        ev_pulse(5);
        repeat (1518) ev_pulse(6);
        cst();
        ev_pulse(6);
        m_fl[6] = 1'b1;
        cst();
        sw(16'h4040);
        ev_pulse(7);
        repeat (90) @(posedge core_clk);
        m_fl[5] = 1'b1;
        cst();
        tend("babble_collision");
        @(posedge core_clk);
        {bm, drq} <= 2'b11;
        repeat (2010) @(posedge core_clk);
        {bm, drq} <= 2'b00;
        m_fl[3] = 1'b1;
        cst();
        sw(16'h2840);
        for (int j = 0; j < 4; j++) begin
            @(posedge core_clk);
            oc <= 4'h1 << j;
            cst();
        end
        @(posedge core_clk);
        oc <= 4'h0;
        tend("grant_pending");
        ev_pulse(1);
        m_fl[2] = 1'b1;
        sw(16'h0004);
        cst();
        sw(16'h0008);
        cst();
        tend("stop");
        // Joint start and init with the receiver disabled
        @(posedge core_clk);
        rxd <= 1'b1;
        sw(16'h0043);
        cst();
        ev_pulse(3);
        {m_fl[0], m_rx, m_tx} = {1'b1, !rxd, !txd};
        cst();
        // Collision seen in time leaves no fault
        ev_pulse(7);
        cp <= 1'b1;
        repeat (90) @(posedge core_clk);
        cp <= 1'b0;
        cst();
        // Link-fail send in twisted-pair mode
        @(posedge core_clk);
        {tp, lf} <= 2'b11;
        ev_pulse(6);
        m_fl[5] = 1'b1;
        cst();
        // Acknowledge in time holds off the grant fault
        @(posedge core_clk);
        {bm, drq, dack} <= 3'b111;
        repeat (2010) @(posedge core_clk);
        {bm, drq, dack} <= 3'b000;
        cst();
        tend("joint_start_pins");
        stop_test();
    end
endmodule : tb_top
